// File: can_guard_pkg.sv
package can_guard_pkg;

   // transceiver modes as programmed by the host
   localparam logic [1:0] MODE_OFF       = 2'h0;
   localparam logic [1:0] MODE_WAKE      = 2'h1;
   localparam logic [1:0] MODE_NORMAL    = 2'h2;
   localparam logic [1:0] MODE_RX_ONLY   = 2'h3;
   localparam logic [1:0] MODE_RESET     = MODE_OFF;

   // register offsets
   localparam logic [3:0] OFS_CTRL       = 4'h0;
   localparam logic [3:0] OFS_STATUS     = 4'h1;
   localparam logic [3:0] OFS_MASK       = 4'h2;
   localparam logic [3:0] OFS_STATE      = 4'h3;
   localparam logic [3:0] OFS_CMD        = 4'h4;

   // ctrl fields
   localparam int CTRL_MODE_LSB          = 0;
   // cmd fields
   localparam int CMD_REENABLE_BIT       = 0;

   // status / mask bit positions
   localparam int ST_BUS_FAIL            = 0;
   localparam int ST_RX_CLAMP            = 1;
   localparam int ST_OVERTEMP            = 2;
   localparam int ST_UNDERVOLT           = 3;
   localparam int ST_WIDTH               = 4;
   localparam logic [ST_WIDTH-1:0] MASK_RESET = 4'hF;

   // state register bit positions
   localparam int SS_TX_EN               = 0;
   localparam int SS_OT_BLOCK            = 1;
   localparam int SS_CLAMP_BLOCK         = 2;
   localparam int SS_OVERTEMP            = 3;
   localparam int SS_UNDERVOLT           = 4;

   // count of bus short sources
   localparam int NUM_SHORTS             = 6;
   localparam int SYNC_STAGES            = 2;

endpackage

// File: can_level_sync.sv
`timescale 1ns/100ps
module can_level_sync
   import can_guard_pkg::*;
#(
   parameter int WIDTH  = 1,
   parameter int STAGES = SYNC_STAGES
) (
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] chain [STAGES];

   // fewer than two stages would not be a synchroniser at all
   if (STAGES < 2 || WIDTH < 1) begin : g_bad_params
      $error("can_level_sync: bad parameters");
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < STAGES; i++) begin
            chain[i] <= '0;
         end
      end else begin
         chain[0] <= async_in;
         for (int i = 1; i < STAGES; i++) begin
            chain[i] <= chain[i-1];
         end
      end
   end

   assign sync_out = chain[STAGES-1];

endmodule

// File: can_transceiver_fault_guard.sv
`timescale 1ns/100ps
module can_transceiver_fault_guard
   import can_guard_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  sys_rst,
   // register port
   input  wire logic [3:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [7:0]            reg_rdata,
   output logic                       irq,
   // host controller side
   input  wire logic                  host_tx,
   output logic                       host_rx,
   // analog front end
   input  wire logic                  bus_rx_level,
   output logic                       driver_tx,
   output logic                       driver_en,
   output logic                       receiver_en,
   output logic                       split_en,
   // detector inputs, asynchronous
   input  wire logic                  overtemp_det,
   input  wire logic                  rx_clamp_det,
   input  wire logic [NUM_SHORTS-1:0] bus_short_det,
   input  wire logic                  supply_uv_det
);

   logic [1:0]          mode;
   logic [ST_WIDTH-1:0] status;
   logic [ST_WIDTH-1:0] mask;
   logic                ot_block;
   logic                clamp_block;
   logic                tx_prev;
   logic                ot_prev;
   logic                clamp_prev;
   logic                uv_prev;

   logic                ot_s;
   logic                clamp_s;
   logic                uv_s;
   logic [NUM_SHORTS-1:0] short_s;
   logic [NUM_SHORTS-1:0] short_prev;

   can_level_sync #(
      .WIDTH  (NUM_SHORTS + 3),
      .STAGES (SYNC_STAGES)
   ) u_sync (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .async_in ({bus_short_det, supply_uv_det, rx_clamp_det,
                  overtemp_det}),
      .sync_out ({short_s, uv_s, clamp_s, ot_s})
   );

   // register decode
   wire wr_ctrl    = reg_wr && (reg_addr == OFS_CTRL);
   wire wr_mask    = reg_wr && (reg_addr == OFS_MASK);
   wire wr_cmd     = reg_wr && (reg_addr == OFS_CMD);
   wire rd_status  = reg_rd && (reg_addr == OFS_STATUS);
   wire reenable   = wr_cmd && reg_wdata[CMD_REENABLE_BIT];

   // event detection on synchronised levels, tx_release on host_tx directly
   wire short_rise = |(short_s & ~short_prev);
   wire clamp_rise = clamp_s && !clamp_prev;
   wire ot_rise    = ot_s && !ot_prev;
   wire uv_rise    = uv_s && !uv_prev;
   wire tx_release = !tx_prev && host_tx;

   wire [ST_WIDTH-1:0] set_bits;
   assign set_bits[ST_BUS_FAIL]  = short_rise;
   assign set_bits[ST_RX_CLAMP]  = clamp_rise;
   assign set_bits[ST_OVERTEMP]  = ot_rise;
   assign set_bits[ST_UNDERVOLT] = uv_rise;

   // read clears, a coinciding set wins
   wire [ST_WIDTH-1:0] next_status = (rd_status ? '0 : status) | set_bits;

   // overtemp block: set while hot, released by a recessive edge after
   wire next_ot_block = ot_s ? 1'b1 :
                        (tx_release ? 1'b0 : ot_block);
   // clamp block: held while clamp persists, released only by command
   wire next_clamp_block = clamp_s ? 1'b1 :
                           (reenable ? 1'b0 : clamp_block);

   wire mode_drives = (mode == MODE_NORMAL);
   wire mode_listens = (mode == MODE_NORMAL) || (mode == MODE_RX_ONLY);
   wire next_driver_en = mode_drives && !next_ot_block
                         && !next_clamp_block;
   wire next_irq = |(next_status & ~mask);

   wire [7:0] state_word = {3'h0, uv_s, ot_s, clamp_block, ot_block,
                            driver_en};
   wire [7:0] rd_mux =
      (reg_addr == OFS_CTRL)   ? {6'h0, mode} :
      (reg_addr == OFS_STATUS) ? {4'h0, status} :
      (reg_addr == OFS_MASK)   ? {4'h0, mask} :
      (reg_addr == OFS_STATE)  ? state_word : 8'h00;

   // mode changes only by host write: faults never touch it
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mode <= MODE_RESET;
      end else if (wr_ctrl) begin
         mode <= reg_wdata[CTRL_MODE_LSB +: 2];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mask <= MASK_RESET;
      end else if (wr_mask) begin
         mask <= reg_wdata[ST_WIDTH-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         status      <= '0;
         ot_block    <= 1'b0;
         clamp_block <= 1'b0;
         tx_prev     <= 1'b1;
         ot_prev     <= 1'b0;
         clamp_prev  <= 1'b0;
         uv_prev     <= 1'b0;
         short_prev  <= '0;
      end else begin
         status      <= next_status;
         ot_block    <= next_ot_block;
         clamp_block <= next_clamp_block;
         tx_prev     <= host_tx;
         ot_prev     <= ot_s;
         clamp_prev  <= clamp_s;
         uv_prev     <= uv_s;
         short_prev  <= short_s;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reg_rdata   <= 8'h00;
         irq         <= 1'b0;
         driver_en   <= 1'b0;
         driver_tx   <= 1'b1;
         receiver_en <= 1'b0;
         split_en    <= 1'b0;
         host_rx     <= 1'b1;
      end else begin
         reg_rdata   <= reg_rd ? rd_mux : 8'h00;
         irq         <= next_irq;
         driver_en   <= next_driver_en;
         driver_tx   <= next_driver_en ? host_tx : 1'b1;
         receiver_en <= mode_listens;
         split_en    <= mode_listens;
         host_rx     <= mode_listens ? bus_rx_level : 1'b1;
      end
   end

endmodule

// File: can_transceiver_fault_guard_sva.sv
`timescale 1ns/100ps
module can_guard_chk (
   input wire logic       ref_clk,
   input wire logic       sys_rst,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       host_tx,
   input wire logic       host_rx,
   input wire logic       bus_rx_level,
   input wire logic       driver_tx,
   input wire logic       driver_en,
   input wire logic       receiver_en,
   input wire logic       split_en,
   input wire logic       overtemp_det,
   input wire logic       rx_clamp_det
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_ot_off; overtemp_det[*4] |-> !driver_en; endproperty
   a_ot_off: assert property (p_ot_off)
      else $error("driver on in overtemp");
   property p_clamp_off; rx_clamp_det[*4] |-> !driver_en; endproperty
   a_clamp_off: assert property (p_clamp_off)
      else $error("driver on with clamp");
   property p_idle_tx; !driver_en |-> driver_tx; endproperty
   a_idle_tx: assert property (p_idle_tx)
      else $error("disabled driver not recessive");
   property p_tx_path; driver_en |-> driver_tx == $past(host_tx); endproperty
   a_tx_path: assert property (p_tx_path)
      else $error("tx path wrong");
   property p_rx_path;
      host_rx == (receiver_en ? $past(bus_rx_level) : 1'b1);
   endproperty
   a_rx_path: assert property (p_rx_path)
      else $error("rx path wrong");
   property p_split; split_en == receiver_en; endproperty
   a_split: assert property (p_split)
      else $error("split mismatch");
   property p_mode_hold;
      !$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(split_en);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode moved without write");
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside slot");
endmodule
bind can_transceiver_fault_guard can_guard_chk chk (.ref_clk, .sys_rst,
   .reg_wr, .reg_rd, .reg_rdata, .host_tx, .host_rx, .bus_rx_level,
   .driver_tx, .driver_en, .receiver_en, .split_en, .overtemp_det,
   .rx_clamp_det);

// File: can_bus_node.sv
`timescale 1ns/100ps
module can_bus_node (
   input  wire logic driver_tx,
   input  wire logic driver_en,
   input  wire logic other_dom,
   output logic      bus_rx_level
);
   // wired bus: any dominant driver wins, recessive when none drives
   assign bus_rx_level = !((driver_en && !driver_tx) || other_dom);
endmodule

// File: tb_can_transceiver_fault_guard.sv
`timescale 1ns/100ps
module tb_can_transceiver_fault_guard;
   import can_guard_pkg::*;
   logic ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, host_tx = 1;
   logic other_dom = 0, overtemp_det = 0, rx_clamp_det = 0, supply_uv_det = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_val;
   logic irq, host_rx, bus_rx_level, driver_tx, driver_en, receiver_en, split_en;
   logic [NUM_SHORTS-1:0] bus_short_det = '0;
   logic [31:0] rng = 32'h0001_4C2E;
   int num_errors = 0, num_checks = 0, cycles = 0;
   can_transceiver_fault_guard dut (.ref_clk, .sys_rst, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .host_tx, .host_rx,
      .bus_rx_level, .driver_tx, .driver_en, .receiver_en, .split_en,
      .overtemp_det, .rx_clamp_det, .bus_short_det, .supply_uv_det);
   can_bus_node bus (.driver_tx, .driver_en, .other_dom, .bus_rx_level);
   initial forever #2.5 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [7:0] exp_on(input logic [1:0] m);
      return 8'(m == MODE_NORMAL || m == MODE_RX_ONLY);
   endfunction
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 16'h1388) begin
         num_errors++;
         test_done();
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   initial begin
      wt(10);
      sys_rst <= 1'b0;
      acc(0, OFS_MASK, 8'h00);
      chk(rd_val, 8'(MASK_RESET));
      acc(0, 4'h9, 8'h00);
      chk(rd_val, 8'h00);
      for (int m = 0; m < 4; m++) begin
         acc(1, OFS_CTRL, 8'(m));
         wt(2);
         chk(8'(split_en), exp_on(2'(m)));
      end
      chk(8'(driver_en), 8'h00);
      acc(1, OFS_CTRL, 8'(MODE_NORMAL));
      repeat (200) begin
         @(posedge ref_clk);
         rng = xs(rng);
         host_tx <= rng[0];
         other_dom <= rng[1] & rng[2];
      end
      // host side: a dominant bit sent on tx must come back on rx
      @(posedge ref_clk) host_tx <= 1'b0;
      other_dom <= 1'b0;
      wt(3);
      chk(8'(host_rx), 8'h00);
      chk(8'(driver_tx), 8'h00);
      @(posedge ref_clk) overtemp_det <= 1'b1;
      host_tx <= 1'b1;
      other_dom <= 1'b0;
      wt(5);
      chk(8'(driver_en), 8'h00);
      @(posedge ref_clk) overtemp_det <= 1'b0;
      host_tx <= 1'b0;
      wt(6);
      chk(8'(driver_en), 8'h00);
      @(posedge ref_clk) host_tx <= 1'b1;
      wt(3);
      chk(8'(driver_en), 8'h01);
      acc(0, OFS_CTRL, 8'h00);
      chk(rd_val, 8'(MODE_NORMAL));
      @(posedge ref_clk) rx_clamp_det <= 1'b1;
      wt(5);
      acc(1, OFS_CMD, 8'h01);
      wt(3);
      chk(8'(driver_en), 8'h00);
      @(posedge ref_clk) rx_clamp_det <= 1'b0;
      wt(6);
      chk(8'(driver_en), 8'h00);
      acc(1, OFS_CMD, 8'h01);
      wt(2);
      chk(8'(driver_en), 8'h01);
      acc(0, OFS_STATUS, 8'h00);
      acc(1, OFS_MASK, 8'h0E);
      for (int i = 0; i < 2 * NUM_SHORTS; i++) begin
         if (i == NUM_SHORTS) acc(1, OFS_MASK, 8'h0F);
         @(posedge ref_clk) bus_short_det <= 6'(1 << (i % NUM_SHORTS));
         wt(6);
         chk(8'(irq), 8'(i < NUM_SHORTS));
         chk(8'(split_en), 8'h01);
         @(posedge ref_clk) bus_short_det <= '0;
         acc(0, OFS_STATUS, 8'h00);
         chk(rd_val, 8'h01);
      end
      @(posedge ref_clk) supply_uv_det <= 1'b1;
      wt(5);
      acc(0, OFS_STATUS, 8'h00);
      chk(rd_val, 8'h08);
      test_done();
   end
endmodule
